//--- verif/fsc_bank_asserts.sv
/*
 port checker of the fault status and clear bank.
 assumes a bind to fsc_bank and the widths of fsc_defs.svh.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fsc_defs.svh"

module fsc_bank_chk (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst,
  // register port
  input wire logic [`FSC_ADDR_W-1:0] reg_addr,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [`FSC_DATA_W-1:0] reg_rdata,
  // watched faults
  input wire logic                   input_overcurrent,
  input wire logic                   logic_supply_low,
  input wire logic                   thermal_trip,
  input wire logic                   current_resistor_short,
  input wire logic                   output_overvolt_low,
  // interrupt
  input wire logic                   irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_clr_zero;
    reg_rd && (reg_addr == `FSC_OFF_SUPPLY || reg_addr == `FSC_OFF_BOOST) |=> (reg_rdata & 16'h5555) == 16'h0000;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear bit reads one");
  property p_in_ocp;
    $past(input_overcurrent && !rst) && reg_rd && reg_addr == `FSC_OFF_SUPPLY |=> reg_rdata[7];
  endproperty
  a_in_ocp: assert property (p_in_ocp) else $error("input overcurrent flag missing");
  property p_logic_low;
    $past(logic_supply_low && !rst) && reg_rd && reg_addr == `FSC_OFF_SUPPLY |=> reg_rdata[5];
  endproperty
  a_logic_low: assert property (p_logic_low) else $error("logic supply flag missing");
  property p_thermal;
    $past(thermal_trip && !rst) && reg_rd && reg_addr == `FSC_OFF_BOOST |=> reg_rdata[15];
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal flag missing");
  property p_iset;
    $past(current_resistor_short && !rst) && reg_rd && reg_addr == `FSC_OFF_BOOST |=> reg_rdata[13];
  endproperty
  a_iset: assert property (p_iset) else $error("resistor short flag missing");
  property p_ovp_low;
    $past(output_overvolt_low && !rst) && reg_rd && reg_addr == `FSC_OFF_BOOST |=> reg_rdata[1];
  endproperty
  a_ovp_low: assert property (p_ovp_low) else $error("overvolt low flag missing");
  property p_irq_fall;
    $fell(irq) |-> $past(reg_wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without a write");
endmodule

bind fsc_bank fsc_bank_chk i_fsc_bank_chk (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .input_overcurrent, .logic_supply_low, .thermal_trip, .current_resistor_short, .output_overvolt_low, .irq);

`default_nettype wire

//--- verif/fsc_bank_bench.sv
/*
 self-checking bench of the fault status and clear bank.
 assumes fsc_host as register master and fault levels driven here.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fsc_defs.svh"

module fsc_bank_bench;
  logic               clk_sys;
  logic               rst;
  logic [15:0]        flt;
  fsc_pkg::fsc_addr_t reg_addr;
  fsc_pkg::fsc_word_t reg_wdata;
  fsc_pkg::fsc_word_t reg_rdata;
  logic               reg_wr;
  logic               reg_rd;
  logic               irq;
  int                 err_count;
  int                 checked;

  fsc_host i_fsc_host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  fsc_bank i_fsc_bank (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .input_undervoltage(flt[0]), .input_overvoltage(flt[1]), .logic_supply_low(flt[2]),
    .input_overcurrent(flt[3]), .pump_capacitor_missing(flt[4]), .pump_fault(flt[5]),
    .sync_input_missing(flt[6]), .checksum_error(flt[7]), .output_overvolt_low(flt[8]),
    .output_overvolt_high(flt[9]), .converter_overcurrent(flt[10]), .freq_resistor_missing(flt[11]),
    .mode_resistor_missing(flt[12]), .string_resistor_missing(flt[13]),
    .current_resistor_short(flt[14]), .thermal_trip(flt[15]), .irq);

  task automatic chk(input string n, input fsc_pkg::fsc_word_t e, input fsc_pkg::fsc_word_t g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rdchk(input fsc_pkg::fsc_addr_t a, input fsc_pkg::fsc_word_t e, input string n);
    fsc_pkg::fsc_word_t g;
    i_fsc_host.rd(a, g);
    chk(n, e, g);
  endtask

  task automatic pulse(input int k);
    @(posedge clk_sys);
    flt[k] <= 1'b1;
    @(posedge clk_sys);
    flt[k] <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic t_reset;
    rdchk(`FSC_OFF_SUPPLY, 16'h0000, "supply_reset");
    rdchk(`FSC_OFF_BOOST, 16'h0000, "boost_reset");
    i_fsc_host.wr(8'h20, 16'hFFFF);
    rdchk(8'h20, 16'h0000, "unmapped");
  endtask

  // every fault: set, sticky, half writes refused, pair clear
  task automatic t_flags;
    fsc_pkg::fsc_addr_t a;
    fsc_pkg::fsc_word_t s;
    for (int k = 0; k < 16; k++) begin
      a = (k < 8) ? `FSC_OFF_SUPPLY : `FSC_OFF_BOOST;
      s = 16'h0002 << (2 * (k % 8));
      @(posedge clk_sys);
      flt[k] <= 1'b1;
      rdchk(a, s, "flag_set");
      flt[k] <= 1'b0;
      i_fsc_host.wr(a, s);
      rdchk(a, s, "status_only");
      i_fsc_host.wr(a, s >> 1);
      rdchk(a, s, "clear_only");
      i_fsc_host.pclr(a, k % 8);
      rdchk(a, 16'h0000, "pair_clear");
    end
  endtask

  task automatic t_irq;
    rdchk(`FSC_OFF_INT_STATUS, 16'h0100, "int_masked");
    chk("irq_masked", 16'h0000, {15'h0000, irq});
    i_fsc_host.wr(`FSC_OFF_INT_CLEAR, 16'h0100);
    i_fsc_host.wr(`FSC_OFF_INT_ENABLE, 16'hFFFF);
    rdchk(`FSC_OFF_INT_ENABLE, 16'hFFFF, "int_enable");
    pulse(15);
    chk("irq_thermal", 16'h0001, {15'h0000, irq});
    i_fsc_host.pclr(`FSC_OFF_BOOST, 7);
    @(posedge clk_sys);
    chk("irq_released", 16'h0000, {15'h0000, irq});
    pulse(8);
    i_fsc_host.pclr(`FSC_OFF_BOOST, 0);
    @(posedge clk_sys);
    chk("irq_ovp_low", 16'h0001, {15'h0000, irq});
    rdchk(`FSC_OFF_BOOST, 16'h0000, "ovp_low_flag");
    i_fsc_host.wr(`FSC_OFF_INT_CLEAR, 16'h0100);
    @(posedge clk_sys);
    chk("irq_int_clear", 16'h0000, {15'h0000, irq});
  endtask

  // a pair clear while the fault stays present loses
  task automatic t_setwins;
    @(posedge clk_sys);
    flt[3] <= 1'b1;
    i_fsc_host.pclr(`FSC_OFF_SUPPLY, 3);
    rdchk(`FSC_OFF_SUPPLY, 16'h0080, "set_wins");
    chk("irq_set_wins", 16'h0001, {15'h0000, irq});
    flt[3] <= 1'b0;
    i_fsc_host.pclr(`FSC_OFF_SUPPLY, 3);
    rdchk(`FSC_OFF_SUPPLY, 16'h0000, "late_clear");
    chk("irq_quiet", 16'h0000, {15'h0000, irq});
  endtask

  // reset in mid-run drops a fresh flag, the enables and the pin
  task automatic t_midreset;
    @(posedge clk_sys);
    flt[15] <= 1'b1;
    @(posedge clk_sys);
    flt[15] <= 1'b0;
    rst     <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst     <= 1'b0;
    rdchk(`FSC_OFF_BOOST, 16'h0000, "boost_midreset");
    rdchk(`FSC_OFF_INT_ENABLE, 16'h0000, "enable_midreset");
    chk("irq_midreset", 16'h0000, {15'h0000, irq});
  endtask

  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    rst       = 1'b1;
    flt       = 16'h0000;
    err_count = 0;
    checked   = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_irq();
    t_setwins();
    t_midreset();
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end
endmodule

`default_nettype wire

//--- verif/fsc_host.sv
/*
 host model: master of the register port.
 assumes one-cycle strobes and read data in the cycle after the strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fsc_defs.svh"

module fsc_host (
  // clock
  input  wire logic                   clk_sys,
  // register port
  output var logic  [`FSC_ADDR_W-1:0] reg_addr,
  output var logic  [`FSC_DATA_W-1:0] reg_wdata,
  output var logic                    reg_wr,
  output var logic                    reg_rd,
  input  wire logic [`FSC_DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // released bus shows inverted values, never the last ones
  task automatic wr(input fsc_pkg::fsc_addr_t a, input fsc_pkg::fsc_word_t d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input fsc_pkg::fsc_addr_t a, output fsc_pkg::fsc_word_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask

  // status and clear of one fault written together
  task automatic pclr(input fsc_pkg::fsc_addr_t a, input int k);
    wr(a, 16'h0003 << (2 * k));
  endtask
endmodule

`default_nettype wire

//--- verilog/fsc_bank.sv
/*
 fault status and clear bank: supply and boost fault registers with
 paired status/clear bits, interrupt status, enable and clear registers
 and one level interrupt output.
 assumes fault inputs are levels synchronous to clk_sys and a register
 port with one-cycle strobes and read data one cycle after the strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fsc_defs.svh"

module fsc_bank (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // register port
  input  wire logic [`FSC_ADDR_W-1:0] reg_addr,
  input  wire logic [`FSC_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`FSC_DATA_W-1:0] reg_rdata,
  // supply fault detectors
  input  wire logic                   checksum_error,
  input  wire logic                   sync_input_missing,
  input  wire logic                   pump_fault,
  input  wire logic                   pump_capacitor_missing,
  input  wire logic                   input_overcurrent,
  input  wire logic                   logic_supply_low,
  input  wire logic                   input_overvoltage,
  input  wire logic                   input_undervoltage,
  // boost fault detectors
  input  wire logic                   thermal_trip,
  input  wire logic                   current_resistor_short,
  input  wire logic                   string_resistor_missing,
  input  wire logic                   mode_resistor_missing,
  input  wire logic                   freq_resistor_missing,
  input  wire logic                   converter_overcurrent,
  input  wire logic                   output_overvolt_high,
  input  wire logic                   output_overvolt_low,
  // interrupt
  output logic                        irq
);

  // fault inputs gathered by index
  fsc_pkg::fsc_group_t supply_fault;
  fsc_pkg::fsc_group_t boost_fault;
  fsc_pkg::fsc_word_t  fault_in;
  fsc_pkg::fsc_word_t  fault_rise;

  assign supply_fault[`FSC_SUP_CHECKSUM]    = checksum_error;
  assign supply_fault[`FSC_SUP_SYNC_MISS]   = sync_input_missing;
  assign supply_fault[`FSC_SUP_PUMP_FAULT]  = pump_fault;
  assign supply_fault[`FSC_SUP_CAP_MISSING] = pump_capacitor_missing;
  assign supply_fault[`FSC_SUP_OVERCURR]    = input_overcurrent;
  assign supply_fault[`FSC_SUP_LOGIC_LOW]   = logic_supply_low;
  assign supply_fault[`FSC_SUP_OVERVOLT]    = input_overvoltage;
  assign supply_fault[`FSC_SUP_UNDERVOLT]   = input_undervoltage;

  assign boost_fault[`FSC_BST_THERMAL]      = thermal_trip;
  assign boost_fault[`FSC_BST_ISET_SHORT]   = current_resistor_short;
  assign boost_fault[`FSC_BST_STRING_RES]   = string_resistor_missing;
  assign boost_fault[`FSC_BST_MODE_RES]     = mode_resistor_missing;
  assign boost_fault[`FSC_BST_FREQ_RES]     = freq_resistor_missing;
  assign boost_fault[`FSC_BST_OVERCURR]     = converter_overcurrent;
  assign boost_fault[`FSC_BST_OVP_HIGH]     = output_overvolt_high;
  assign boost_fault[`FSC_BST_OVP_LOW]      = output_overvolt_low;

  assign fault_in = {boost_fault, supply_fault};

  // address decode
  logic hit_supply;
  logic hit_boost;
  logic hit_int_status;
  logic hit_int_enable;
  logic hit_int_clear;
  logic wr_supply;
  logic wr_boost;
  logic wr_int_enable;
  logic wr_int_clear;

  assign hit_supply     = (reg_addr == `FSC_OFF_SUPPLY);
  assign hit_boost      = (reg_addr == `FSC_OFF_BOOST);
  assign hit_int_status = (reg_addr == `FSC_OFF_INT_STATUS);
  assign hit_int_enable = (reg_addr == `FSC_OFF_INT_ENABLE);
  assign hit_int_clear  = (reg_addr == `FSC_OFF_INT_CLEAR);

  assign wr_supply      = reg_wr & hit_supply;
  assign wr_boost       = reg_wr & hit_boost;
  assign wr_int_enable  = reg_wr & hit_int_enable;
  assign wr_int_clear   = reg_wr & hit_int_clear;

  // pair-clear requests: status and clear bit both written as one
  fsc_pkg::fsc_group_t supply_pair;
  fsc_pkg::fsc_group_t boost_pair;
  fsc_pkg::fsc_word_t  flag_clr;
  fsc_pkg::fsc_word_t  pin_clr;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pair
      assign supply_pair[gi] = wr_supply & reg_wdata[`FSC_STAT_POS(gi)] & reg_wdata[`FSC_CLR_POS(gi)];
      assign boost_pair[gi]  = wr_boost & reg_wdata[`FSC_STAT_POS(gi)] & reg_wdata[`FSC_CLR_POS(gi)];
    end
  endgenerate

  assign flag_clr = {boost_pair, supply_pair};

  // the boost low-threshold pair clears only the register flag
  fsc_pkg::fsc_group_t boost_pin_pair;

  assign boost_pin_pair = boost_pair & ~(8'h01 << `FSC_BST_OVP_LOW);
  assign pin_clr        = {boost_pin_pair, supply_pair} | (wr_int_clear ? reg_wdata : `FSC_RST_FLAGS);

  // new-fault pulses for the interrupt status
  fsc_rise u_rise (
    .clk_sys (clk_sys),
    .rst     (rst),
    .level   (fault_in),
    .pulse   (fault_rise)
  );

  // sticky fault flags and interrupt status bits
  fsc_pkg::fsc_word_t flag;
  fsc_pkg::fsc_word_t int_status;

  generate
    for (gi = 0; gi < `FSC_NUM_FAULTS; gi = gi + 1) begin : g_flag
      fsc_sticky u_flag (
        .clk_sys (clk_sys),
        .rst     (rst),
        .set     (fault_in[gi]),
        .clr     (flag_clr[gi]),
        .q       (flag[gi])
      );

      // a fault still present after a pair clear raises the pin again
      fsc_sticky u_int (
        .clk_sys (clk_sys),
        .rst     (rst),
        .set     (fault_rise[gi] | (fault_in[gi] & flag_clr[gi])),
        .clr     (pin_clr[gi]),
        .q       (int_status[gi])
      );
    end
  endgenerate

  // interrupt enable register
  fsc_pkg::fsc_word_t int_enable_r;
  fsc_pkg::fsc_word_t int_enable_nxt;

  assign int_enable_nxt = wr_int_enable ? reg_wdata : int_enable_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_enable_r <= `FSC_RST_INT_ENABLE;
    end else begin
      int_enable_r <= int_enable_nxt;
    end
  end

  assign irq = |(int_status & int_enable_r);

  // register views: status bit odd, clear bit reads zero
  fsc_pkg::fsc_word_t supply_view;
  fsc_pkg::fsc_word_t boost_view;

  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_view
      assign supply_view[`FSC_STAT_POS(gi)] = flag[gi];
      assign supply_view[`FSC_CLR_POS(gi)]  = 1'b0;
      assign boost_view[`FSC_STAT_POS(gi)]  = flag[`FSC_INT_BOOST_BASE + gi];
      assign boost_view[`FSC_CLR_POS(gi)]   = 1'b0;
    end
  endgenerate

  // read select and registered read data
  fsc_pkg::fsc_sel_t  rd_sel;
  fsc_pkg::fsc_word_t rd_mux;
  fsc_pkg::fsc_word_t rdata_r;
  fsc_pkg::fsc_word_t rdata_nxt;

  assign rd_sel = !reg_rd         ? fsc_pkg::FSC_SEL_NONE :
                  hit_supply      ? fsc_pkg::FSC_SEL_SUPPLY :
                  hit_boost       ? fsc_pkg::FSC_SEL_BOOST :
                  hit_int_status  ? fsc_pkg::FSC_SEL_INT_STATUS :
                  hit_int_enable  ? fsc_pkg::FSC_SEL_INT_ENABLE :
                                    fsc_pkg::FSC_SEL_NONE;

  always_comb begin
    unique case (rd_sel)
      fsc_pkg::FSC_SEL_SUPPLY:     rd_mux = supply_view;
      fsc_pkg::FSC_SEL_BOOST:      rd_mux = boost_view;
      fsc_pkg::FSC_SEL_INT_STATUS: rd_mux = int_status;
      fsc_pkg::FSC_SEL_INT_ENABLE: rd_mux = int_enable_r;
      fsc_pkg::FSC_SEL_NONE:       rd_mux = `FSC_RST_RDATA;
      default:                     rd_mux = `FSC_RST_RDATA;
    endcase
  end

  // data stand only in the cycle after the read strobe
  assign rdata_nxt = rd_mux;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= `FSC_RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

`default_nettype wire

//--- verilog/fsc_defs.svh
/*
 constants of the fault status and clear bank: offsets, field positions,
 reset values. assumes a 16-bit register port with byte offsets as printed.
*/
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

`define FSC_ADDR_W          8
`define FSC_DATA_W          16
`define FSC_NUM_FAULTS      16

// register offsets
`define FSC_OFF_SUPPLY      8'h0E
`define FSC_OFF_BOOST       8'h10
`define FSC_OFF_INT_STATUS  8'h18
`define FSC_OFF_INT_ENABLE  8'h1A
`define FSC_OFF_INT_CLEAR   8'h1C

// reset values
`define FSC_RST_FLAGS       16'h0000
`define FSC_RST_INT_ENABLE  16'h0000
`define FSC_RST_RDATA       16'h0000

// fault indices: status bit at 2*idx+1, clear bit at 2*idx of its register
`define FSC_SUP_UNDERVOLT   0
`define FSC_SUP_OVERVOLT    1
`define FSC_SUP_LOGIC_LOW   2
`define FSC_SUP_OVERCURR    3
`define FSC_SUP_CAP_MISSING 4
`define FSC_SUP_PUMP_FAULT  5
`define FSC_SUP_SYNC_MISS   6
`define FSC_SUP_CHECKSUM    7
`define FSC_BST_OVP_LOW     0
`define FSC_BST_OVP_HIGH    1
`define FSC_BST_OVERCURR    2
`define FSC_BST_FREQ_RES    3
`define FSC_BST_MODE_RES    4
`define FSC_BST_STRING_RES  5
`define FSC_BST_ISET_SHORT  6
`define FSC_BST_THERMAL     7
`define FSC_STAT_POS(i)     (2*(i)+1)
`define FSC_CLR_POS(i)      (2*(i))
// interrupt layout: supply faults in bits 7..0, boost faults in bits 15..8
`define FSC_INT_BOOST_BASE  8

`endif

//--- verilog/fsc_pkg.sv
/*
 types of the fault status and clear bank.
 assumes fsc_defs.svh for widths.
*/
`default_nettype none
`include "fsc_defs.svh"

package fsc_pkg;
  typedef logic [`FSC_DATA_W-1:0] fsc_word_t;
  typedef logic [`FSC_ADDR_W-1:0] fsc_addr_t;
  typedef logic [7:0]             fsc_group_t;
  typedef enum logic [2:0] {
    FSC_SEL_NONE,
    FSC_SEL_SUPPLY,
    FSC_SEL_BOOST,
    FSC_SEL_INT_STATUS,
    FSC_SEL_INT_ENABLE
  } fsc_sel_t;
endpackage

`default_nettype wire

//--- verilog/fsc_rise.sv
/*
 rising edge detector for the fault inputs, one pulse per new fault.
 assumes fault inputs synchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fsc_defs.svh"

module fsc_rise (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // levels in, pulses out
  input  wire logic [`FSC_NUM_FAULTS-1:0] level,
  output logic      [`FSC_NUM_FAULTS-1:0] pulse
);

  logic [`FSC_NUM_FAULTS-1:0] prev_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_r <= `FSC_RST_FLAGS;
    end else begin
      prev_r <= level;
    end
  end

  assign pulse = level & ~prev_r;

endmodule

`default_nettype wire

//--- verilog/fsc_sticky.sv
/*
 one sticky flag: set by an event, cleared by a request, set wins.
 assumes synchronous active-high reset on clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none

module fsc_sticky (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // control
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      q
);

  logic q_r;
  logic q_nxt;

  // an event in the clearing cycle is kept
  assign q_nxt = set | (q_r & ~clr);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire
